// ---- rtl/vpst_consts.svh ----
// register offsets, field positions, reset values and timing counts of the video port
// Functional notes
// - after reset the port runs as sync master, driving strobe, line and frame sync
// - free running strobe toggles at fixed period; each word launched on active edge
// - data ready strobe pulses at programmed level only while a valid word stands
// - default strobe free running, active low, period of two hclk cycles, launch edge selectable
// - level line sync active from row start until the row's last pixel, strobe aligned
// - pulse line sync at each row end, at least four strobe cycles, programmable polarity
// - first pixel with line sync by default; optionally 0 to 15 dummy pixels first
// - level frame sync active from frame start until the frame's last pixel
// - pulse frame sync at frame end, at least four hclk cycles, default active low
// - odd/even mode shows the field on frame sync, polarity still honoured
// - slave mode takes both syncs as trigger inputs and waits for the row trigger before each row
// - first pixel comes 124 plus column start mclk periods after the row trigger; the code then waits for the next launch and one more slot
// - row trigger active level programmable, default high
// - frame trigger resets the row counter; level programmable, default high
// - pixel bus floats while the bus float bit of mode b is set
// - slave select is bit 2 of main config one; clear means master
// - hclk comes from mclk through an 8-bit divider; zero means hclk equals mclk
`ifndef VPST_CONSTS_SVH
`define VPST_CONSTS_SVH
`define VPST_OFS_MAIN_CONFIG_ONE     8'h03
`define VPST_OFS_CLOCK_DIVIDER       8'h05
`define VPST_OFS_MODE_A              8'h06
`define VPST_OFS_MODE_B              8'h07
`define VPST_OFS_MODE_C              8'h08
`define VPST_OFS_SCAN_FIRST_ROW      8'h0b
`define VPST_OFS_SCAN_LAST_ROW       8'h0c
`define VPST_OFS_DISPLAY_FIRST_ROW   8'h0e
`define VPST_OFS_DISPLAY_LAST_ROW    8'h0f
`define VPST_OFS_DISPLAY_FIRST_COL   8'h10
`define VPST_OFS_DISPLAY_LAST_COL    8'h11
`define VPST_OFS_DISPLAY_LOW_BITS    8'h12
`define VPST_OFS_ROW_GAP_HIGH        8'h15
`define VPST_OFS_ROW_GAP_LOW         8'h16
`define VPST_OFS_FRAME_GAP_HIGH      8'h17
`define VPST_OFS_FRAME_GAP_LOW       8'h18
`define VPST_OFS_STATUS              8'h1a
`define VPST_RST_ZERO                8'h00
`define VPST_RST_CLOCK_DIVIDER       8'h04
`define VPST_RST_LAST_ROW            8'hfb
`define VPST_RST_LAST_COL            8'ha5
`define VPST_RST_LOW_BITS            8'h32
`define VPST_BIT_SLAVE_SELECT        2
`define VPST_BIT_STROBE_DATA_READY   0
`define VPST_BIT_STROBE_FALLING      1
`define VPST_BIT_STROBE_LEVEL_HIGH   2
`define VPST_BIT_LINE_PULSE          0
`define VPST_BIT_LINE_ACTIVE_LOW     1
`define VPST_BIT_FRAME_PULSE         2
`define VPST_BIT_FRAME_ACTIVE_HIGH   3
`define VPST_BIT_ODD_EVEN            4
`define VPST_BIT_BUS_FLOAT           5
`define VPST_BIT_ROW_TRIG_LOW        6
`define VPST_BIT_FRAME_TRIG_LOW      7
`define VPST_ROW_TRIG_BASE           10'd124
`define VPST_SYNC_LATENCY            10'd3
`define VPST_PULSE_SLOTS             16'h0004
`endif

// ---- rtl/vpst_pkg.sv ----
// types shared by the video port sync timing block
package vpst_pkg;
	typedef enum logic [2:0] {
		VPST_IDLE,
		VPST_DUMMY,
		VPST_ACTIVE,
		VPST_ROW_GAP,
		VPST_FRAME_GAP
	} vpst_state_t;

	typedef struct packed {
		logic       slave;
		logic       data_ready;
		logic       falling;
		logic       strobe_high;
		logic       line_pulse;
		logic       line_low;
		logic       frame_pulse;
		logic       frame_high;
		logic       odd_even;
		logic       bus_float;
		logic       row_trig_low;
		logic       frame_trig_low;
		logic [3:0] dummy;
	} vpst_cfg_t;
endpackage : vpst_pkg

// ---- rtl/vpst_top.sv ----
// video port sync timing: pixel fifo and master/slave sync generator
`include "vpst_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module vpst_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
	end

	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_valid = count != '0;
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) wr_ptr <= wr_ptr + 1'b1;
			if (pop) rd_ptr <= rd_ptr + 1'b1;
			if (push && !pop) count <= count + 1'b1;
			else if (pop && !push) count <= count - 1'b1;
		end
	end

	// ready from the next count, so the top's ready pin leaves a flop
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) in_ready <= 1'b0;
		else in_ready <= count + (AW+1)'(push) - (AW+1)'(pop) != (AW+1)'(DEPTH);
	end
endmodule : vpst_fifo

module vpst_top #(
	parameter int DATA_W     = 12,
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	output logic      [7:0]        reg_rdata,
	input  wire logic              pix_valid,
	input  wire logic [DATA_W-1:0] pix_data,
	output logic                   pix_ready,
	output logic      [DATA_W-1:0] d_out,
	output logic                   d_oe,
	output logic                   pclk_out,
	output logic                   pclk_oe,
	input  wire logic              hsync_in,
	output logic                   hsync_out,
	output logic                   hsync_oe,
	input  wire logic              vsync_in,
	output logic                   vsync_out,
	output logic                   vsync_oe
);
	logic [7:0] main_config_one;
	logic [7:0] sensor_clock_divider_reg;
	logic [7:0] video_port_mode_a;
	logic [7:0] video_port_mode_b;
	logic [7:0] video_port_mode_c;
	logic [7:0] scan_first_row;
	logic [7:0] scan_last_row;
	logic [7:0] display_first_row;
	logic [7:0] display_last_row;
	logic [7:0] display_first_column;
	logic [7:0] display_last_column;
	logic [7:0] display_window_low_bits;
	logic [7:0] row_gap_high;
	logic [7:0] row_gap_low;
	logic [7:0] frame_gap_high;
	logic [7:0] frame_gap_low;

	vpst_pkg::vpst_cfg_t   cfg;
	vpst_pkg::vpst_state_t state;
	logic [7:0]            div_cnt;
	logic                  hclk_tick;
	logic                  phase;
	logic                  launch;
	logic                  mid;
	logic                  fifo_valid;
	logic [DATA_W-1:0]     fifo_data;
	logic                  take;
	logic [10:0]           col;
	logic [10:0]           last_col;
	logic [9:0]            row;
	logic [9:0]            last_row;
	logic [3:0]            dummy_cnt;
	logic [15:0]           gap_cnt;
	logic [15:0]           row_gap;
	logic [15:0]           frame_gap;
	logic                  frame_on;
	logic                  field;
	logic                  word_out;
	logic                  hs_s1;
	logic                  hs_s2;
	logic                  vs_s1;
	logic                  vs_s2;
	logic                  hs_prev;
	logic                  vs_prev;
	logic                  row_trig;
	logic                  frame_trig;
	logic [9:0]            trig_cnt;
	logic                  trig_run;
	logic                  row_go;
	logic                  frame_rst;
	logic                  in_row;

	initial begin
		if (DATA_W != 12) $error("pixel bus is twelve bits wide");
		if (FIFO_DEPTH != 16) $error("pixel fifo depth must be 16");
	end

	assign cfg.slave          = main_config_one[`VPST_BIT_SLAVE_SELECT];
	assign cfg.data_ready     = video_port_mode_a[`VPST_BIT_STROBE_DATA_READY];
	assign cfg.falling        = video_port_mode_a[`VPST_BIT_STROBE_FALLING];
	assign cfg.strobe_high    = video_port_mode_a[`VPST_BIT_STROBE_LEVEL_HIGH];
	assign cfg.line_pulse     = video_port_mode_b[`VPST_BIT_LINE_PULSE];
	assign cfg.line_low       = video_port_mode_b[`VPST_BIT_LINE_ACTIVE_LOW];
	assign cfg.frame_pulse    = video_port_mode_b[`VPST_BIT_FRAME_PULSE];
	assign cfg.frame_high     = video_port_mode_b[`VPST_BIT_FRAME_ACTIVE_HIGH];
	assign cfg.odd_even       = video_port_mode_b[`VPST_BIT_ODD_EVEN];
	assign cfg.bus_float      = video_port_mode_b[`VPST_BIT_BUS_FLOAT];
	assign cfg.row_trig_low   = video_port_mode_b[`VPST_BIT_ROW_TRIG_LOW];
	assign cfg.frame_trig_low = video_port_mode_b[`VPST_BIT_FRAME_TRIG_LOW];
	assign cfg.dummy          = video_port_mode_c[3:0];

	// register writes from the serial engine, same clock
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			main_config_one          <= `VPST_RST_ZERO;
			sensor_clock_divider_reg <= `VPST_RST_CLOCK_DIVIDER;
			video_port_mode_a        <= `VPST_RST_ZERO;
			video_port_mode_b        <= `VPST_RST_ZERO;
			video_port_mode_c        <= `VPST_RST_ZERO;
			scan_first_row           <= `VPST_RST_ZERO;
			scan_last_row            <= `VPST_RST_LAST_ROW;
			display_first_row        <= `VPST_RST_ZERO;
			display_last_row         <= `VPST_RST_LAST_ROW;
			display_first_column     <= `VPST_RST_ZERO;
			display_last_column      <= `VPST_RST_LAST_COL;
			display_window_low_bits  <= `VPST_RST_LOW_BITS;
			row_gap_high             <= `VPST_RST_ZERO;
			row_gap_low              <= `VPST_RST_ZERO;
			frame_gap_high           <= `VPST_RST_ZERO;
			frame_gap_low            <= `VPST_RST_ZERO;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`VPST_OFS_MAIN_CONFIG_ONE:   main_config_one          <= reg_wdata & 8'hf4;
				`VPST_OFS_CLOCK_DIVIDER:     sensor_clock_divider_reg <= reg_wdata;
				`VPST_OFS_MODE_A:            video_port_mode_a        <= reg_wdata;
				`VPST_OFS_MODE_B:            video_port_mode_b        <= reg_wdata;
				`VPST_OFS_MODE_C:            video_port_mode_c        <= reg_wdata;
				`VPST_OFS_SCAN_FIRST_ROW:    scan_first_row           <= reg_wdata;
				`VPST_OFS_SCAN_LAST_ROW:     scan_last_row            <= reg_wdata;
				`VPST_OFS_DISPLAY_FIRST_ROW: display_first_row        <= reg_wdata;
				`VPST_OFS_DISPLAY_LAST_ROW:  display_last_row         <= reg_wdata;
				`VPST_OFS_DISPLAY_FIRST_COL: display_first_column     <= reg_wdata;
				`VPST_OFS_DISPLAY_LAST_COL:  display_last_column      <= reg_wdata;
				`VPST_OFS_DISPLAY_LOW_BITS:  display_window_low_bits  <= reg_wdata;
				`VPST_OFS_ROW_GAP_HIGH:      row_gap_high             <= reg_wdata;
				`VPST_OFS_ROW_GAP_LOW:       row_gap_low              <= reg_wdata;
				`VPST_OFS_FRAME_GAP_HIGH:    frame_gap_high           <= reg_wdata;
				`VPST_OFS_FRAME_GAP_LOW:     frame_gap_low            <= reg_wdata;
				default: ;
			endcase
		end
	end

	// register reads, one cycle late; unmapped reads as zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`VPST_OFS_MAIN_CONFIG_ONE:   reg_rdata <= main_config_one;
				`VPST_OFS_CLOCK_DIVIDER:     reg_rdata <= sensor_clock_divider_reg;
				`VPST_OFS_MODE_A:            reg_rdata <= video_port_mode_a;
				`VPST_OFS_MODE_B:            reg_rdata <= video_port_mode_b;
				`VPST_OFS_MODE_C:            reg_rdata <= video_port_mode_c;
				`VPST_OFS_SCAN_FIRST_ROW:    reg_rdata <= scan_first_row;
				`VPST_OFS_SCAN_LAST_ROW:     reg_rdata <= scan_last_row;
				`VPST_OFS_DISPLAY_FIRST_ROW: reg_rdata <= display_first_row;
				`VPST_OFS_DISPLAY_LAST_ROW:  reg_rdata <= display_last_row;
				`VPST_OFS_DISPLAY_FIRST_COL: reg_rdata <= display_first_column;
				`VPST_OFS_DISPLAY_LAST_COL:  reg_rdata <= display_last_column;
				`VPST_OFS_DISPLAY_LOW_BITS:  reg_rdata <= display_window_low_bits;
				`VPST_OFS_ROW_GAP_HIGH:      reg_rdata <= row_gap_high;
				`VPST_OFS_ROW_GAP_LOW:       reg_rdata <= row_gap_low;
				`VPST_OFS_FRAME_GAP_HIGH:    reg_rdata <= frame_gap_high;
				`VPST_OFS_FRAME_GAP_LOW:     reg_rdata <= frame_gap_low;
				`VPST_OFS_STATUS:            reg_rdata <= {4'h0, !fifo_valid, field, frame_on, in_row};
				default:                     reg_rdata <= 8'h00;
			endcase
		end
	end

	// hclk enable; divisor 0 and 1 both give hclk = mclk
	assign hclk_tick = div_cnt == 8'h00;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div_cnt <= 8'h00;
		end else if (hclk_tick) begin
			div_cnt <= (sensor_clock_divider_reg > 8'h01) ? sensor_clock_divider_reg - 8'h01 : 8'h00;
		end else begin
			div_cnt <= div_cnt - 8'h01;
		end
	end

	// one pixel slot is two hclk ticks, since a flop pin can toggle at most once per tick
	assign launch = hclk_tick && !phase;
	assign mid    = hclk_tick && phase;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			phase <= 1'b0;
		end else if (hclk_tick) begin
			phase <= !phase;
		end
	end

	// pixel strobe
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pclk_out <= 1'b0;
		end else if (!cfg.data_ready) begin
			if (hclk_tick) pclk_out <= !phase ^ cfg.falling;
		end else if (mid && word_out) begin
			pclk_out <= cfg.strobe_high;
		end else if (launch) begin
			pclk_out <= !cfg.strobe_high;
		end
	end

	// slave trigger inputs: two-flop synchronisers, then edge on the active level
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hs_s1   <= 1'b0;
			hs_s2   <= 1'b0;
			vs_s1   <= 1'b0;
			vs_s2   <= 1'b0;
			hs_prev <= 1'b0;
			vs_prev <= 1'b0;
		end else begin
			hs_s1   <= hsync_in;
			hs_s2   <= hs_s1;
			vs_s1   <= vsync_in;
			vs_s2   <= vs_s1;
			hs_prev <= hs_s2 ^ cfg.row_trig_low;
			vs_prev <= vs_s2 ^ cfg.frame_trig_low;
		end
	end
	assign row_trig   = cfg.slave && (hs_s2 ^ cfg.row_trig_low) && !hs_prev;
	assign frame_trig = cfg.slave && (vs_s2 ^ cfg.frame_trig_low) && !vs_prev;

	// row trigger to first pixel delay, counted in mclk less synchroniser latency
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			trig_cnt <= 10'd0;
			trig_run <= 1'b0;
			row_go   <= 1'b0;
		end else begin
			if (row_trig) begin
				trig_cnt <= `VPST_ROW_TRIG_BASE + {2'b00, display_first_column} - `VPST_SYNC_LATENCY;
				trig_run <= 1'b1;
			end else if (trig_run && trig_cnt != 10'd0) begin
				trig_cnt <= trig_cnt - 10'd1;
			end else begin
				trig_run <= 1'b0;
			end
			if (trig_run && trig_cnt == 10'd0) row_go <= 1'b1;
			else if (launch && state == vpst_pkg::VPST_IDLE) row_go <= 1'b0;
		end
	end

	// frame trigger noted until the next slot boundary
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			frame_rst <= 1'b0;
		end else if (frame_trig) begin
			frame_rst <= 1'b1;
		end else if (launch) begin
			frame_rst <= 1'b0;
		end
	end

	assign last_col  = 11'({display_last_column, 2'b11}) - 11'({display_first_column, 2'b00});
	assign last_row  = 10'({display_last_row, 1'b1}) - 10'({display_first_row, 1'b0});
	assign row_gap   = ({row_gap_high, row_gap_low} > `VPST_PULSE_SLOTS) ? {row_gap_high, row_gap_low} : `VPST_PULSE_SLOTS;
	assign frame_gap = ({frame_gap_high, frame_gap_low} > `VPST_PULSE_SLOTS) ?
		{frame_gap_high, frame_gap_low} : `VPST_PULSE_SLOTS;
	assign take      = launch && state == vpst_pkg::VPST_ACTIVE && fifo_valid;
	assign in_row    = state == vpst_pkg::VPST_DUMMY || state == vpst_pkg::VPST_ACTIVE;

	vpst_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.nrst      (nrst),
		.in_valid  (pix_valid),
		.in_data   (pix_data),
		.in_ready  (pix_ready),
		.out_valid (fifo_valid),
		.out_data  (fifo_data),
		.out_ready (take)
	);

	// row and frame sequencer, advancing once per pixel slot
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state     <= vpst_pkg::VPST_IDLE;
			col       <= 11'd0;
			row       <= 10'd0;
			dummy_cnt <= 4'h0;
			gap_cnt   <= 16'h0000;
			frame_on  <= 1'b0;
			field     <= 1'b0;
		end else if (launch) begin
			if (frame_rst) row <= 10'd0;
			unique case (state)
				vpst_pkg::VPST_IDLE: begin
					if (!cfg.slave || row_go) begin
						if (!frame_on) field <= !field;
						frame_on  <= 1'b1;
						col       <= 11'd0;
						dummy_cnt <= cfg.dummy;
						state     <= (cfg.dummy != 4'h0) ? vpst_pkg::VPST_DUMMY : vpst_pkg::VPST_ACTIVE;
					end
				end
				vpst_pkg::VPST_DUMMY: begin
					dummy_cnt <= dummy_cnt - 4'h1;
					if (dummy_cnt == 4'h1) state <= vpst_pkg::VPST_ACTIVE;
				end
				vpst_pkg::VPST_ACTIVE: begin
					if (fifo_valid) begin
						col <= col + 11'd1;
						if (col == last_col) begin
							gap_cnt <= 16'h0000;
							if (row == last_row) begin
								row      <= 10'd0;
								frame_on <= 1'b0;
								state    <= vpst_pkg::VPST_FRAME_GAP;
							end else begin
								if (!frame_rst) row <= row + 10'd1;
								state <= vpst_pkg::VPST_ROW_GAP;
							end
						end
					end
				end
				vpst_pkg::VPST_ROW_GAP: begin
					gap_cnt <= gap_cnt + 16'h0001;
					if (gap_cnt == row_gap - 16'h0001) state <= vpst_pkg::VPST_IDLE;
				end
				vpst_pkg::VPST_FRAME_GAP: begin
					gap_cnt <= gap_cnt + 16'h0001;
					if (gap_cnt == frame_gap - 16'h0001) state <= vpst_pkg::VPST_IDLE;
				end
			endcase
		end
	end

	// pixel bus and data ready marker
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			d_out    <= '0;
			word_out <= 1'b0;
		end else if (launch) begin
			word_out <= take || state == vpst_pkg::VPST_DUMMY;
			if (take) d_out <= fifo_data;
			else if (state == vpst_pkg::VPST_DUMMY) d_out <= '0;
		end
	end

	// sync outputs change only at launch, from the state of that slot
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hsync_out <= 1'b0;
			vsync_out <= 1'b1;
		end else if (launch) begin
			if (cfg.line_pulse) begin
				hsync_out <= ((state == vpst_pkg::VPST_ROW_GAP || state == vpst_pkg::VPST_FRAME_GAP) &&
					gap_cnt < `VPST_PULSE_SLOTS) ^ cfg.line_low;
			end else begin
				hsync_out <= in_row ^ cfg.line_low;
			end
			if (cfg.odd_even) begin
				vsync_out <= !(field ^ cfg.frame_high);
			end else if (cfg.frame_pulse) begin
				vsync_out <= !((state == vpst_pkg::VPST_FRAME_GAP && gap_cnt < `VPST_PULSE_SLOTS) ^ cfg.frame_high);
			end else begin
				vsync_out <= !((frame_on && state != vpst_pkg::VPST_FRAME_GAP) ^ cfg.frame_high);
			end
		end
	end

	// pin enables; slave mode releases both sync pins to the external master
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			d_oe     <= 1'b0;
			pclk_oe  <= 1'b0;
			hsync_oe <= 1'b0;
			vsync_oe <= 1'b0;
		end else begin
			d_oe     <= !cfg.bus_float;
			pclk_oe  <= 1'b1;
			hsync_oe <= !cfg.slave;
			vsync_oe <= !cfg.slave;
		end
	end
endmodule : vpst_top

`default_nettype wire

// ---- verification/vpst_top_asserts.sv ----
// port checks for the video port sync timing block
`timescale 1ns/1ps
`default_nettype none
module vpst_top_asserts #(
	parameter int DATA_W     = 12,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic              clk,
	input wire logic              nrst,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [7:0]        reg_addr,
	input wire logic [7:0]        reg_wdata,
	input wire logic [7:0]        reg_rdata,
	input wire logic [DATA_W-1:0] d_out,
	input wire logic              d_oe,
	input wire logic              pclk_out,
	input wire logic              pclk_oe,
	input wire logic              hsync_out,
	input wire logic              hsync_oe,
	input wire logic              vsync_out,
	input wire logic              vsync_oe
);
	logic [7:0] ma, mb, mc;
	logic [4:0] qcnt;
	logic       quiet, hs_act, vs_act;
	// config shadows are trusted only once writes have settled for a while
	assign quiet = qcnt == 5'h1f;
	assign hs_act = hsync_out ^ mb[1];
	assign vs_act = vsync_out ^ ~mb[3];
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) qcnt <= 5'h00;
		else if (reg_wr) qcnt <= 5'h00;
		else if (!quiet) qcnt <= qcnt + 5'h01;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ma <= 8'h00;
			mb <= 8'h00;
			mc <= 8'h00;
		end else if (reg_wr) begin
			if (reg_addr == 8'h06) ma <= reg_wdata;
			if (reg_addr == 8'h07) mb <= reg_wdata;
			if (reg_addr == 8'h03) mc <= reg_wdata;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_hs_hold; (hs_act || !quiet)[*8]; endsequence
	sequence s_vs_hold; (vs_act || !quiet)[*8]; endsequence
	a_oe_after_reset: assert property ($past(nrst) |-> pclk_oe) else $error("strobe not driven");
	a_reset_idle: assert property ($rose(nrst) |-> vsync_out && !hsync_out && !d_oe) else $error("reset levels");
	a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata)) else $error("read data moved");
	a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00) else $error("unmapped read");
	a_mode_read: assert property (reg_rd && !reg_wr && reg_addr == 8'h06 |=> reg_rdata == ma) else $error("mode read");
	a_d_word_hold: assert property ($changed(d_out) |=> $stable(d_out)) else $error("word too short");
	a_bus_float: assert property (quiet |-> d_oe == !mb[5]) else $error("bus float wrong");
	a_slave_oe: assert property (quiet |-> hsync_oe == !mc[2] && vsync_oe == !mc[2]) else $error("sync dir wrong");
	a_line_hold: assert property ($rose(hs_act) && quiet && hsync_oe |-> s_hs_hold) else $error("line sync short");
	a_frame_hold: assert property ($rose(vs_act) && quiet && vsync_oe |-> s_vs_hold) else $error("frame sync short");
	a_free_strobe: assert property (quiet && !ma[0] && !mc[2] && pclk_oe |-> ##[1:260] $changed(pclk_out))
		else $error("strobe stopped");
endmodule : vpst_top_asserts
bind vpst_top vpst_top_asserts #(.DATA_W(DATA_W), .FIFO_DEPTH(FIFO_DEPTH)) vpst_top_asserts_i (.clk(clk), .nrst(nrst),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.d_out(d_out), .d_oe(d_oe), .pclk_out(pclk_out), .pclk_oe(pclk_oe), .hsync_out(hsync_out),
	.hsync_oe(hsync_oe), .vsync_out(vsync_out), .vsync_oe(vsync_oe));
`default_nettype wire

// ---- verification/vpst_dip_model.sv ----
// receiving image processor: strobe capture and slave triggers
`timescale 1ns/1ps
`default_nettype none
module vpst_dip_model (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        pclk_out,
	input  wire logic [11:0] d_out,
	input  wire logic        cap_en,
	input  wire logic        go,
	output logic             got,
	output logic      [11:0] word,
	output logic             row_trig,
	output logic             frame_trig
);
	logic       pp;
	logic [1:0] tcnt;
	assign row_trig = tcnt != 2'h0;
	assign frame_trig = tcnt == 2'h3;
	// takes the word at the strobe's falling edge, mid slot, where the bus is settled
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pp <= 1'b1;
			got <= 1'b0;
			word <= 12'h000;
			tcnt <= 2'h0;
		end else begin
			pp <= pclk_out;
			got <= pp && !pclk_out && cap_en;
			word <= d_out;
			tcnt <= go ? 2'h3 : tcnt - {1'b0, row_trig};
		end
	end
endmodule : vpst_dip_model
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the video port sync timing block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, pix_valid = 1'b0, go = 1'b0;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [11:0] pix_data = 12'h000, d_out, word;
	logic        pix_ready, d_oe, pclk_out, pclk_oe, hsync_out, hsync_oe, vsync_out, vsync_oe;
	logic        got, row_trig, frame_trig, rd_d = 1'b0, cap_en = 1'b0;
	logic [7:0]  rq[$];
	logic [11:0] pq[$];
	int          miscompares = 0, checks_done = 0, seed = 22391, refusals = 0, n;
	longint      t0;
	logic [7:0]  ra[17] = '{8'h03, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0b, 8'h0c, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12,
		8'h15, 8'h16, 8'h17, 8'h18, 8'h00};
	logic [7:0]  rv[17] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'hfb, 8'h00, 8'hfb, 8'h00, 8'ha5, 8'h32,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	always #20 clk = ~clk;
	vpst_top vpst_top_i (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pix_valid(pix_valid), .pix_data(pix_data),
		.pix_ready(pix_ready), .d_out(d_out), .d_oe(d_oe), .pclk_out(pclk_out), .pclk_oe(pclk_oe),
		.hsync_in(hsync_oe ? hsync_out : row_trig), .hsync_out(hsync_out), .hsync_oe(hsync_oe),
		.vsync_in(vsync_oe ? vsync_out : frame_trig), .vsync_out(vsync_out), .vsync_oe(vsync_oe));
	vpst_dip_model vpst_dip_model_i (.clk(clk), .nrst(nrst), .pclk_out(pclk_out), .d_out(d_out),
		.cap_en(cap_en), .go(go), .got(got), .word(word), .row_trig(row_trig), .frame_trig(frame_trig));
	task automatic cmp_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp_reg
	task automatic cmp_pix(input string nm, input logic [11:0] e, input logic [11:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp_pix
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] v);
		rq.push_back(v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask : rd
	// valid stays up between words so back-to-back pushes never drop it; push never clears it, drain and the slave sequence do
	task automatic push(input logic [11:0] v, input logic note);
		logic r;
		pix_valid <= 1'b1;
		pix_data <= v;
		if (note) pq.push_back(v);
		do begin
			@(negedge clk);
			r = pix_ready;
			if (!r) refusals++;
			@(posedge clk);
		end while (!r);
	endtask : push
	task automatic drain;
		pix_valid <= 1'b0;
		for (n = 0; n < 4000 && pq.size() != 0; n++) @(posedge clk);
		cmp_reg("words left", 8'h00, 8'(pq.size()));
	endtask : drain
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish
	always @(posedge clk) begin
		rd_d <= reg_rd;
		cap_en <= pq.size() != 0;
		if (rd_d) cmp_reg("reg_rdata", rq.pop_front(), reg_rdata);
		if (got) cmp_pix("pixel", (pq.size() != 0) ? pq.pop_front() : 12'hxxx, word);
	end
	initial begin
		#(40 * 40000);
		miscompares++;
		tally_and_finish;
	end
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 17; i++) rd(ra[i], rv[i]);
		wr(8'h03, 8'hff);
		rd(8'h03, 8'hf4);
		wr(8'h03, 8'h00);
		wr(8'h11, 8'h00);
		wr(8'h0f, 8'h00);
		wr(8'h07, 8'h05);
		wr(8'h06, 8'h01);
		rd(8'h06, 8'h01);
		for (int i = 0; i < 20; i++) push(12'($random(seed)), 1'b1);
		cmp_reg("fifo refused", 8'h01, 8'(refusals != 0));
		drain;
		wr(8'h08, 8'h0f);
		for (int r = 0; r < 2; r++) begin
			repeat (15) pq.push_back(12'h000);
			for (int i = 0; i < 4; i++) push(12'($random(seed)), 1'b1);
		end
		drain;
		wr(8'h08, 8'h00);
		wr(8'h07, 8'h20);
		repeat (8) @(posedge clk);
		cmp_reg("d_oe", 8'h00, {7'h00, d_oe});
		wr(8'h07, 8'h1a);
		wr(8'h06, 8'h02);
		for (int i = 0; i < 3; i++) begin
			wr(8'h05, (i == 0) ? 8'h00 : 8'(i + 2));
			repeat (40) @(posedge clk);
			@(posedge pclk_out);
			t0 = $time;
			@(posedge pclk_out);
			cmp_reg("strobe period", (i == 0) ? 8'h02 : 8'(2 * (i + 2)), 8'(($time - t0) / 40));
			@(posedge clk);
		end
		// fresh reset; the row begun before the slave write is closed with zero words
		nrst <= 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		wr(8'h03, 8'h04);
		wr(8'h10, 8'h02);
		wr(8'h11, 8'h02);
		cmp_reg("hsync_oe", 8'h00, {7'h00, hsync_oe});
		repeat (4) push(12'h000, 1'b0);
		push(12'h5a5, 1'b0);
		pix_valid <= 1'b0;
		repeat (300) @(posedge clk);
		cmp_pix("d_out untriggered", 12'h000, d_out);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		t0 = $time;
		@(d_out);
		cmp_reg("trigger delay ok", 8'h01, 8'(($time - t0) / 40 >= 126 && ($time - t0) / 40 <= 140));
		cmp_pix("d_out triggered", 12'h5a5, d_out);
		tally_and_finish;
	end
endmodule : tb
`default_nettype wire
